// *** design/sgcr_age_timer.sv ***
// age tick generator with normal and fast periods
module sgcr_age_timer #(
  parameter int unsigned FAST_CYCLES = 8000,
  parameter int unsigned NORMAL_CYCLES = 2000000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic fast,
  input wire logic restart,
  // event
  output logic tick
);

  // three cycles at least, so two fast ticks never fall on neighbouring or next-but-one edges
  if (FAST_CYCLES < 3 || NORMAL_CYCLES < 3) begin : gBadPeriod
    $error("age periods must be at least three cycles");
  end

  localparam logic [31:0] FAST_LAST = 32'(FAST_CYCLES - 1);
  localparam logic [31:0] NORMAL_LAST = 32'(NORMAL_CYCLES - 1);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic tick_reg;
  wire logic [31:0] lastCount = fast ? FAST_LAST : NORMAL_LAST;
  wire logic atLast = cnt_reg >= lastCount;

  assign cnt_next = (restart || !run || atLast) ? 32'h00000000 : cnt_reg + 32'h00000001;
  assign tick = tick_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      tick_reg <= run && !restart && atLast;
    end
  end

endmodule

// *** design/sgcr_global_ctrl.sv ***
// global control registers of the switch engine with aging control
//
// Overview of operation
// - bit 7 of first register selects the new back-off algorithm
// - pass flow-control bit set forwards flow-control frames, else filters
// - any port losing link ages out every learned address entry
// - pass-all bit with sniffer mode switches errored frames too; length check and flow-control filtering still drop
// - transmit flow control bit cleared means no PAUSE frame is generated
// - receive flow control bit cleared means received PAUSE frames are ignored
// - length check drops frames with length field below 1500 not matching
// - aging enable bit turns periodic aging on or off at normal or fast period; link-loss fast age cycles run either way
// - fast age bit ages the table with the 800 us period
// - aggressive back-off bit selects non-standard half-duplex back-off
module sgcr_global_ctrl
  import sgcr_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter int unsigned FAST_CYCLES = sgcr_pkg::SGCR_FAST_AGE_CYCLES,
  parameter int unsigned NORMAL_CYCLES = sgcr_pkg::SGCR_NORMAL_AGE_CYCLES
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // management register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // switch engine configuration
  output sgcr_pkg::sgcr_ctrl_type ctrl,
  input wire logic snifferMode,
  // port link pins
  input wire logic [NUM_PORTS-1:0] linkUpPin,
  // frame screening
  input wire sgcr_pkg::sgcr_frame_type frameIn,
  output sgcr_pkg::sgcr_verdict_type verdict,
  // pause generation
  input wire logic [NUM_PORTS-1:0] pauseWanted,
  output logic [NUM_PORTS-1:0] pauseSend,
  // address table aging
  output logic ageTick,
  output logic flushAll
);
  import sgcr_pkg::*;

  if (NUM_PORTS < 1 || NUM_PORTS > 8) begin : gBadPorts
    $error("NUM_PORTS must be between 1 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] rdData_reg;
  wire logic hitCtrl0 = regAddr == SGCR_OFS_CTRL0;
  wire logic hitCtrl1 = regAddr == SGCR_OFS_CTRL1;
  wire logic [7:0] rdMux = hitCtrl0 ? ctrl0_reg : hitCtrl1 ? ctrl1_reg : SGCR_RD_UNMAPPED;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl0_reg <= SGCR_RST_CTRL0;
      ctrl1_reg <= SGCR_RST_CTRL1;
      rdData_reg <= SGCR_RD_UNMAPPED;
    end else if (ce) begin
      if (regWrEn && hitCtrl0) begin
        ctrl0_reg <= regWrData;
      end
      if (regWrEn && hitCtrl1) begin
        ctrl1_reg <= regWrData;
      end
      if (regRdEn) begin
        rdData_reg <= rdMux;
      end
    end
  end

  assign regRdData = rdData_reg;

  // reserved bits are stored as written; software keeps them at reset value
  assign ctrl.newBackoff = ctrl0_reg[SGCR_B0_NEW_BACKOFF];
  assign ctrl.passFlowCtrl = ctrl0_reg[SGCR_B0_PASS_FC];
  assign ctrl.linkAgeEn = ctrl0_reg[SGCR_B0_LINK_AGE];
  assign ctrl.passAll = ctrl1_reg[SGCR_B1_PASS_ALL];
  assign ctrl.txFlowEn = ctrl1_reg[SGCR_B1_TX_FC];
  assign ctrl.rxFlowEn = ctrl1_reg[SGCR_B1_RX_FC];
  assign ctrl.lenCheck = ctrl1_reg[SGCR_B1_LEN_CHECK];
  assign ctrl.agingEn = ctrl1_reg[SGCR_B1_AGING];
  assign ctrl.fastAgeEn = ctrl1_reg[SGCR_B1_FAST_AGE];
  assign ctrl.aggrBackoff = ctrl1_reg[SGCR_B1_AGGR_BACKOFF];

  ////////////////////////////////////////////////////////////////////////////////
  // frame screening and pause

  sgcr_verdict_type verdict_reg;
  logic [NUM_PORTS-1:0] pauseSend_reg;
  wire logic lenMismatch = ctrl.lenCheck && frameIn.lenType < SGCR_LEN_LIMIT
    && frameIn.lenType != frameIn.actualLen;
  wire logic fcFiltered = frameIn.isFlowCtrl && !ctrl.passFlowCtrl;
  wire logic passBad = ctrl.passAll && snifferMode;
  wire logic badDropped = frameIn.badFrame && !passBad;
  wire logic forwardNow = !lenMismatch && !fcFiltered && !badDropped;
  wire logic honourNow = frameIn.isPause && ctrl.rxFlowEn;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      verdict_reg <= '0;
      pauseSend_reg <= '0;
    end else if (ce) begin
      verdict_reg <= '{valid: frameIn.valid, forward: frameIn.valid && forwardNow,
                       honourPause: frameIn.valid && honourNow};
      pauseSend_reg <= pauseWanted & {NUM_PORTS{ctrl.txFlowEn}};
    end
  end

  assign verdict = verdict_reg;
  assign pauseSend = pauseSend_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // link loss detection

  logic [NUM_PORTS-1:0] linkMeta_reg;
  logic [NUM_PORTS-1:0] linkSync_reg;
  logic [NUM_PORTS-1:0] linkPrev_reg;
  logic [NUM_PORTS-1:0] linkLost;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : gLink
      assign linkLost[gp] = linkPrev_reg[gp] && !linkSync_reg[gp];
    end
  endgenerate

  wire logic anyLinkLost = |linkLost;

  ////////////////////////////////////////////////////////////////////////////////
  // aging

  sgcr_age_state_type age_reg;
  sgcr_age_state_type age_next;
  logic flush_reg;
  logic timerTick;
  wire logic fastCycleStart = anyLinkLost && ctrl.linkAgeEn;
  wire logic inFastCycle = age_reg == SGCR_AGE_LINKFAST;
  wire logic timerRun = ctrl.agingEn || inFastCycle;
  wire logic timerFast = ctrl.fastAgeEn || inFastCycle;

  always_comb begin
    age_next = age_reg;
    case (age_reg)
      SGCR_AGE_NORMAL: begin
        if (fastCycleStart) begin
          age_next = SGCR_AGE_LINKFAST;
        end
      end
      SGCR_AGE_LINKFAST: begin
        if (timerTick && !fastCycleStart) begin
          age_next = SGCR_AGE_NORMAL;
        end
      end
      default: age_next = SGCR_AGE_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      linkMeta_reg <= '0;
      linkSync_reg <= '0;
      linkPrev_reg <= '0;
      age_reg <= SGCR_AGE_NORMAL;
      flush_reg <= 1'b0;
    end else if (ce) begin
      linkMeta_reg <= linkUpPin;
      linkSync_reg <= linkMeta_reg;
      linkPrev_reg <= linkSync_reg;
      age_reg <= age_next;
      flush_reg <= anyLinkLost;
    end
  end

  sgcr_age_timer #(
    .FAST_CYCLES(FAST_CYCLES),
    .NORMAL_CYCLES(NORMAL_CYCLES)
  ) uAgeTimer (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .run(timerRun),
    .fast(timerFast),
    .restart(fastCycleStart),
    .tick(timerTick)
  );

  assign ageTick = timerTick;
  assign flushAll = flush_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_ctrl0_write_lands: assert property (
    ce && regWrEn && hitCtrl0 |=> ctrl0_reg == $past(regWrData))
    else $error("first control register did not take the write");
  a_backoff_follows_bit: assert property (
    ce && regWrEn && hitCtrl0 |=> ctrl.newBackoff == $past(regWrData[SGCR_B0_NEW_BACKOFF]))
    else $error("new back-off select does not follow its bit");
  a_fc_frame_filter: assert property (
    ce && frameIn.valid && frameIn.isFlowCtrl && !ctrl.passFlowCtrl |=> !verdict.forward)
    else $error("flow-control frame forwarded while filtering");
  a_bad_frame_pass: assert property (
    ce && frameIn.valid && frameIn.badFrame && !(ctrl.passAll && snifferMode)
    |=> verdict.valid && !verdict.forward)
    else $error("bad frame forwarded outside sniffer pass-all");
  a_pause_tx_block: assert property (
    ce && !ctrl.txFlowEn |=> pauseSend == '0)
    else $error("pause generated with transmit flow control off");
  a_pause_rx_ignore: assert property (
    ce && frameIn.valid && !ctrl.rxFlowEn |=> !verdict.honourPause)
    else $error("received pause honoured with receive flow control off");
  a_len_check_drop: assert property (
    ce && frameIn.valid && ctrl.lenCheck && frameIn.lenType < SGCR_LEN_LIMIT
    && frameIn.lenType != frameIn.actualLen |=> !verdict.forward)
    else $error("length mismatch frame forwarded");
  a_aging_off_quiet: assert property (
    !ctrl.agingEn && !$past(ctrl.agingEn) && !inFastCycle && !$past(inFastCycle)
    |-> !ageTick)
    else $error("age tick while aging disabled");
  a_link_loss_flush: assert property (
    ce && anyLinkLost |=> flushAll)
    else $error("link loss did not flush the address table");
  a_link_fast_start: assert property (
    ce && fastCycleStart |=> inFastCycle)
    else $error("link loss did not start a fast age cycle");
  a_fast_age_period: assert property (
    ce && ageTick && timerFast && !fastCycleStart
    |-> !$past(ageTick) && !$past(ageTick, 2))
    else $error("fast age ticks closer than the fast period");

  c_link_fast_cycle: cover property (inFastCycle && timerTick);
  c_sniffer_bad_pass: cover property (frameIn.valid && frameIn.badFrame && passBad);
  c_len_drop: cover property (frameIn.valid && lenMismatch);
  c_ctrl1_write: cover property (regWrEn && hitCtrl1);

endmodule

// *** design/sgcr_pkg.sv ***
// constants and carrier types for the switch global control registers
package sgcr_pkg;

  // register offsets on the management port
  localparam logic [7:0] SGCR_OFS_CTRL0 = 8'h02;
  localparam logic [7:0] SGCR_OFS_CTRL1 = 8'h03;

  // reset values
  localparam logic [7:0] SGCR_RST_CTRL0 = 8'h44;
  localparam logic [7:0] SGCR_RST_CTRL1 = 8'h30;
  localparam logic [7:0] SGCR_RD_UNMAPPED = 8'h00;

  // field positions, first control register
  localparam int SGCR_B0_NEW_BACKOFF = 7;
  localparam int SGCR_B0_PASS_FC = 3;
  localparam int SGCR_B0_LINK_AGE = 0;

  // field positions, second control register
  localparam int SGCR_B1_PASS_ALL = 7;
  localparam int SGCR_B1_TX_FC = 5;
  localparam int SGCR_B1_RX_FC = 4;
  localparam int SGCR_B1_LEN_CHECK = 3;
  localparam int SGCR_B1_AGING = 2;
  localparam int SGCR_B1_FAST_AGE = 1;
  localparam int SGCR_B1_AGGR_BACKOFF = 0;

  // frame length field limit
  localparam logic [15:0] SGCR_LEN_LIMIT = 16'h05DC;

  // timing
  localparam int unsigned SGCR_CLK_NS = 100;
  localparam int unsigned SGCR_FAST_AGE_NS = 800000;
  localparam int unsigned SGCR_NORMAL_AGE_MS = 200000;
  localparam int unsigned SGCR_FAST_AGE_CYCLES = SGCR_FAST_AGE_NS / SGCR_CLK_NS;
  localparam int unsigned SGCR_NORMAL_AGE_CYCLES =
    SGCR_NORMAL_AGE_MS * (1000000 / SGCR_CLK_NS);

  typedef struct packed {
    logic newBackoff;
    logic aggrBackoff;
    logic passFlowCtrl;
    logic passAll;
    logic txFlowEn;
    logic rxFlowEn;
    logic lenCheck;
    logic agingEn;
    logic fastAgeEn;
    logic linkAgeEn;
  } sgcr_ctrl_type;

  typedef struct packed {
    logic valid;
    logic isFlowCtrl;
    logic isPause;
    logic badFrame;
    logic [15:0] lenType;
    logic [15:0] actualLen;
  } sgcr_frame_type;

  typedef struct packed {
    logic valid;
    logic forward;
    logic honourPause;
  } sgcr_verdict_type;

  typedef enum logic {SGCR_AGE_NORMAL, SGCR_AGE_LINKFAST} sgcr_age_state_type;

endpackage

// *** verification/sgcr_tb.sv ***
// self-checking bench for the switch global control registers
module tb;
  import sgcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic snifferMode = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  sgcr_ctrl_type ctrl;
  logic [2:0] linkUpPin = 3'h7;
  logic [2:0] pauseWanted = 3'h0;
  logic [2:0] pauseSend;
  sgcr_frame_type frameIn = '0;
  sgcr_verdict_type verdict;
  logic ageTick;
  logic flushAll;
  int failCount = 0;
  int checked = 0;
  int n;

  sgcr_global_ctrl #(.NUM_PORTS(3), .FAST_CYCLES(8), .NORMAL_CYCLES(20)) uut (
    .clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .ctrl(ctrl),
    .snifferMode(snifferMode), .linkUpPin(linkUpPin), .frameIn(frameIn),
    .verdict(verdict), .pauseWanted(pauseWanted), .pauseSend(pauseSend),
    .ageTick(ageTick), .flushAll(flushAll));

  initial begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // every task starts and ends just after a rising edge
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    step;
    regWrEn = 1'b0;
    step;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    step;
    regRdEn = 1'b0;
    chk(regRdData, e, "read data");
    step;
  endtask

  // waits for ageTick (sel 0) or flushAll (sel 1); n counts edges waited
  task automatic waitp(input bit sel, input int lim, output int cnt);
    cnt = 0;
    while (((sel ? flushAll : ageTick) !== 1'b1) && cnt < lim) begin
      step;
      cnt++;
    end
    if (cnt >= lim) begin
      failCount++;
      $display("CHECK FAILED at %0t: pulse timeout", $time);
      results;
    end
  endtask

  task automatic noTick(input int cyc);
    int c;
    c = 0;
    repeat (cyc) begin
      step;
      if (ageTick === 1'b1) c++;
    end
    chk(c[15:0], 16'h0000, "unexpected age tick");
  endtask

  task automatic frm(input logic fc, p, b, sn, input logic [15:0] lt, al,
                     input logic f, h);
    snifferMode = sn;
    frameIn = {1'b1, fc, p, b, lt, al};
    step;
    frameIn.valid = 1'b0;
    chk({verdict.valid, verdict.forward, verdict.honourPause}, {1'b1, f, h}, "verdict");
    step;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'h02, 8'h44);
    rd(8'h03, 8'h30);
    rd(8'h10, 8'h00);
    chk(ctrl, 10'h030, "ctrl defaults");
    chk({pauseSend, ageTick, flushAll}, 5'h00, "outputs idle");
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(8'h02, 8'hCD);
    chk({ctrl.newBackoff, ctrl.passFlowCtrl, ctrl.linkAgeEn}, 3'h7, "ctrl0 fields");
    wr(8'h03, 8'h31);
    chk({ctrl.aggrBackoff, ctrl.agingEn}, 2'h2, "ctrl1 fields");
    wr(8'h05, 8'hFF);
    ce = 1'b0;
    wr(8'h02, 8'h44);
    ce = 1'b1;
    rd(8'h02, 8'hCD);
    rd(8'h03, 8'h31);
    wr(8'h02, 8'h44);
    wr(8'h03, 8'h30);
    chk(ctrl, 10'h030, "ctrl restored");
    $display("test registers done");
  endtask

  task automatic t_frames;
    frm(0, 0, 0, 0, 16'h0064, 16'h0032, 1, 0);
    frm(0, 1, 0, 0, 16'h0040, 16'h0040, 1, 1);
    frm(1, 0, 0, 0, 16'h0040, 16'h0040, 0, 0);
    frm(0, 0, 1, 1, 16'h0040, 16'h0040, 0, 0);
    wr(8'h02, 8'h4C);
    wr(8'h03, 8'hB8);
    chk(ctrl, 10'h0F8, "ctrl live update");
    frm(1, 0, 0, 0, 16'h0040, 16'h0040, 1, 0);
    frm(0, 0, 0, 0, 16'h05DB, 16'h0032, 0, 0);
    frm(0, 0, 0, 0, 16'h05DC, 16'h0032, 1, 0);
    frm(0, 0, 0, 0, 16'h0064, 16'h0064, 1, 0);
    frm(0, 0, 1, 0, 16'h0040, 16'h0040, 0, 0);
    frm(0, 0, 1, 1, 16'h0040, 16'h0040, 1, 0);
    wr(8'h02, 8'h44);
    $display("test frames done");
  endtask

  task automatic t_pause;
    wr(8'h03, 8'h30);
    pauseWanted = 3'h5;
    step;
    step;
    chk(pauseSend, 3'h5, "pause on");
    wr(8'h03, 8'h10);
    step;
    chk(pauseSend, 3'h0, "pause off");
    pauseWanted = 3'h0;
    wr(8'h03, 8'h20);
    frm(0, 1, 0, 0, 16'h0040, 16'h0040, 1, 0);
    wr(8'h03, 8'h30);
    $display("test pause done");
  endtask

  task automatic t_age;
    wr(8'h03, 8'h36);
    chk(ctrl, 10'h036, "ctrl aging fields");
    waitp(0, 30, n);
    step;
    waitp(0, 30, n);
    chk(16'(n + 1), 16'h0008, "fast period");
    wr(8'h03, 8'h34);
    waitp(0, 40, n);
    step;
    waitp(0, 40, n);
    chk(16'(n + 1), 16'h0014, "normal period");
    wr(8'h03, 8'h30);
    noTick(50);
    $display("test aging done");
  endtask

  task automatic t_link;
    wr(8'h02, 8'h45);
    linkUpPin[1] = 1'b0;
    waitp(1, 10, n);
    chk(16'(n), 16'h0003, "flush delay");
    step;
    chk(flushAll, 1'b0, "flush width");
    waitp(0, 20, n);
    chk(16'(n + 1), 16'h0008, "fast cycle length");
    noTick(40);
    linkUpPin[1] = 1'b1;
    repeat (4) step;
    wr(8'h02, 8'hC4);
    linkUpPin[2] = 1'b0;
    waitp(1, 10, n);
    noTick(30);
    rstn = 1'b0;
    step;
    rstn = 1'b1;
    step;
    rd(8'h02, 8'h44);
    $display("test link done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    step;
    t_reset;
    t_regs;
    t_frames;
    t_pause;
    t_age;
    t_link;
    results;
  end
endmodule
